// >>> dbs_boot_sequencer.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "dbs_regs.svh"
module dbs_boot_sequencer (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // boot straps from pins
  input wire logic [1:0] BOOT_MODE,
  input wire logic PCI_SEL,
  input wire logic LITTLE_ENDIAN,
  // host side, same clock
  input wire logic HOST_INT_SET,
  // cpu side, same clock
  input wire logic CPU_INT_CLR,
  output logic CPU_STALL,
  output logic CPU_START,
  output logic [31:0] CPU_START_ADDR,
  output logic CPU_HOST_IRQ,
  output logic PERIPH_RUN,
  // host-side access grant
  output logic HPI_MEM_EN,
  output logic PCI_MEM_EN,
  // external memory port, ROM reads
  output logic ROM_RD_REQ,
  output logic [9:0] ROM_ADDR,
  output logic ROM_DFLT_TIMING,
  input wire logic ROM_RD_ACK,
  input wire logic [7:0] ROM_RD_DATA,
  // internal memory writes
  output logic MEM_WR_REQ,
  output logic [7:0] MEM_WR_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_WR_ACK,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // interrupt
  output logic IRQ
);

  // pin synchronisers: stage one is read only by stage two
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {LITTLE_ENDIAN, PCI_SEL, BOOT_MODE};
      sync2 <= sync1;
    end
  end

  dbs_pkg::dbs_state_t state;
  dbs_pkg::dbs_state_t next_state;
  dbs_pkg::dbs_mode_t mode;
  logic pci;
  logic le;
  logic [1:0] settle;
  logic hint;
  logic [9:0] byte_cnt;
  logic [31:0] pack;
  wire [3:0] status;
  logic [3:0] enable;

  // strap decode; an unused fourth code falls back to no boot
  wire [1:0] pin_mode = sync2[1:0];
  dbs_pkg::dbs_mode_t pin_mode_dec;
  assign pin_mode_dec = (pin_mode == `DBS_PIN_HOST) ? dbs_pkg::MODE_HOST :
                        (pin_mode == `DBS_PIN_ROM) ? dbs_pkg::MODE_ROM :
                        dbs_pkg::MODE_NONE;

  // event decode
  wire hint_try = HOST_INT_SET;
  wire hint_take = hint_try && (!hint || CPU_INT_CLR);
  wire hint_refuse = hint_try && !hint_take;
  wire host_release = (state == dbs_pkg::ST_HOST_WAIT) && hint_take;
  wire rom_got = (state == dbs_pkg::ST_ROM_READ) && ROM_RD_ACK;
  wire word_full = rom_got && (byte_cnt[1:0] == 2'h3);
  wire wr_done = (state == dbs_pkg::ST_ROM_WRITE) && MEM_WR_ACK;
  wire rom_last = wr_done && (byte_cnt == 10'h0);
  wire rom_release = rom_last;
  wire sample_now = (state == dbs_pkg::ST_SAMPLE);
  wire none_release = sample_now && (pin_mode_dec == dbs_pkg::MODE_NONE);
  wire any_release = host_release || rom_release || none_release;
  wire [31:0] next_pack = le ? {ROM_RD_DATA, pack[31:8]} : {pack[23:0], ROM_RD_DATA};
  wire [3:0] evt = {hint_refuse, hint_take, rom_release, host_release};

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      dbs_pkg::ST_SETTLE: begin
        if (settle == `DBS_SYNC_CYC) begin
          next_state = dbs_pkg::ST_SAMPLE;
        end
      end
      dbs_pkg::ST_SAMPLE: begin
        unique case (pin_mode_dec)
          dbs_pkg::MODE_HOST: next_state = dbs_pkg::ST_HOST_WAIT;
          dbs_pkg::MODE_ROM: next_state = dbs_pkg::ST_ROM_READ;
          dbs_pkg::MODE_NONE: next_state = dbs_pkg::ST_RUN;
          default: next_state = dbs_pkg::ST_RUN;
        endcase
      end
      dbs_pkg::ST_HOST_WAIT: begin
        if (host_release) begin
          next_state = dbs_pkg::ST_RUN;
        end
      end
      dbs_pkg::ST_ROM_READ: begin
        if (word_full) begin
          next_state = dbs_pkg::ST_ROM_WRITE;
        end
      end
      dbs_pkg::ST_ROM_WRITE: begin
        if (rom_last) begin
          next_state = dbs_pkg::ST_RUN;
        end else if (wr_done) begin
          next_state = dbs_pkg::ST_ROM_READ;
        end
      end
      dbs_pkg::ST_RUN: next_state = dbs_pkg::ST_RUN;
    endcase
  end

  // state, straps and settle counter; straps caught once, after release
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= dbs_pkg::ST_SETTLE;
      settle <= 2'h0;
      mode <= dbs_pkg::MODE_NONE;
      pci <= 1'b0;
      le <= 1'b0;
    end else begin
      state <= next_state;
      if (state == dbs_pkg::ST_SETTLE) begin
        settle <= settle + 2'h1;
      end
      if (sample_now) begin
        mode <= pin_mode_dec;
        pci <= sync2[2];
        le <= sync2[3];
      end
    end
  end

  // cpu stall and start; stall covers reset so the cpu never runs early
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CPU_STALL <= 1'b1;
      CPU_START <= 1'b0;
      PERIPH_RUN <= 1'b0;
      CPU_START_ADDR <= `DBS_START_ADDR;
    end else begin
      CPU_START <= any_release;
      if (any_release) begin
        CPU_STALL <= 1'b0;
      end
      if (sample_now) begin
        PERIPH_RUN <= 1'b1;
      end
    end
  end

  // host access grant, only the selected port opens, for read and write
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HPI_MEM_EN <= 1'b0;
      PCI_MEM_EN <= 1'b0;
    end else if (sample_now) begin
      HPI_MEM_EN <= !sync2[2];
      PCI_MEM_EN <= sync2[2];
    end
  end

  // host-to-cpu interrupt bit; a set in the clearing cycle still lands
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hint <= 1'b0;
      CPU_HOST_IRQ <= 1'b0;
    end else begin
      hint <= hint_take || (hint && !CPU_INT_CLR);
      CPU_HOST_IRQ <= hint_take && !CPU_STALL;
    end
  end

  // block copy: read bytes, pack, write words; count runs up and ends at its wrap to zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      byte_cnt <= 10'h0;
      pack <= 32'h0;
      ROM_RD_REQ <= 1'b0;
      ROM_ADDR <= 10'h0;
      ROM_DFLT_TIMING <= 1'b0;
      MEM_WR_REQ <= 1'b0;
      MEM_WR_ADDR <= 8'h0;
      MEM_WDATA <= 32'h0;
    end else begin
      if (sample_now && pin_mode_dec == dbs_pkg::MODE_ROM) begin
        ROM_RD_REQ <= 1'b1;
        ROM_DFLT_TIMING <= 1'b1;
      end
      if (rom_got) begin
        pack <= next_pack;
        byte_cnt <= byte_cnt + 10'h1;
        ROM_ADDR <= byte_cnt + 10'h1;
        if (word_full) begin
          ROM_RD_REQ <= 1'b0;
          MEM_WR_REQ <= 1'b1;
          MEM_WDATA <= next_pack;
          MEM_WR_ADDR <= byte_cnt[9:2];
        end
      end
      if (wr_done) begin
        MEM_WR_REQ <= 1'b0;
        ROM_RD_REQ <= !rom_last;
        if (rom_last) begin
          ROM_DFLT_TIMING <= 1'b0;
        end
      end
    end
  end

  // register decode
  wire wr_clear = WR && (ADDR == `DBS_OFS_CLEAR);
  wire wr_enable = WR && (ADDR == `DBS_OFS_ENABLE);
  wire [31:0] info = {27'h0, hint, CPU_STALL, pci, mode};
  wire [31:0] rd_mux = (ADDR == `DBS_OFS_STATUS) ? {28'h0, status} :
                       (ADDR == `DBS_OFS_ENABLE) ? {28'h0, enable} :
                       (ADDR == `DBS_OFS_INFO) ? info : 32'h0;

  // sticky status, one flop per event; set beats a coincident clear
  // each flop is private to its loop pass, so no two processes share a variable
  genvar gi;
  generate
    for (gi = 0; gi < `DBS_NUM_EVT; gi++) begin : g_evt
      logic flag;
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          flag <= 1'b0;
        end else begin
          flag <= evt[gi] || (flag && !(wr_clear && WDATA[gi]));
        end
      end
      assign status[gi] = flag;
    end
  endgenerate

  // enable, read data for one cycle only, interrupt level
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      enable <= `DBS_RST_ENABLE;
      RDATA <= 32'h0;
      IRQ <= 1'b0;
    end else begin
      if (wr_enable) begin
        enable <= WDATA[3:0];
      end
      RDATA <= RD ? rd_mux : 32'h0;
      IRQ <= |(status & enable);
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_host_go;
    state == dbs_pkg::ST_HOST_WAIT && HOST_INT_SET;
  endsequence
  sequence s_released;
    !CPU_STALL && CPU_START;
  endsequence
  // a word write waiting for its acknowledge
  sequence s_word_wait;
    MEM_WR_REQ && !MEM_WR_ACK;
  endsequence
  // a byte read waiting for its acknowledge
  sequence s_byte_wait;
    ROM_RD_REQ && !ROM_RD_ACK;
  endsequence

  AST_HOST_RELEASE: assert property (s_host_go |=> s_released)
    else $error("host boot not released by interrupt bit");
  AST_NO_LATCH: assert property (s_host_go |=> !CPU_HOST_IRQ)
    else $error("releasing interrupt reached the cpu");
  AST_ROM_HOLD: assert property (mode == dbs_pkg::MODE_ROM && state != dbs_pkg::ST_RUN
      |-> CPU_STALL)
    else $error("cpu left stall during rom copy");
  AST_REFUSE: assert property (hint && HOST_INT_SET && !CPU_INT_CLR
      |=> !CPU_HOST_IRQ && status[`DBS_BIT_HINT_REFUSED])
    else $error("second interrupt accepted before clear");
  AST_ROM_DONE: assert property (wr_done && byte_cnt == 10'h0
      |=> !CPU_STALL && !ROM_RD_REQ ##1 !CPU_START)
    else $error("rom copy end did not release cpu");
  AST_PACK: assert property (word_full |=> MEM_WR_REQ && MEM_WDATA == pack)
    else $error("packed word not presented");
  AST_NONE: assert property (sample_now && pin_mode_dec == dbs_pkg::MODE_NONE
      |=> !CPU_STALL && CPU_START_ADDR == 32'h0)
    else $error("no boot did not start at zero");
  // the strap copy moves at the sampling edge, so the cycle after it is skipped
  AST_MODE_HOLD: assert property (state != dbs_pkg::ST_SETTLE && !sample_now
      && !$past(sample_now) |-> $stable(mode) && $stable(pci))
    else $error("strap copy changed after sampling");
  AST_PORT_SEL: assert property (sample_now |=> HPI_MEM_EN == !pci && PCI_MEM_EN == pci)
    else $error("host port selection wrong");
  AST_STALL_START: assert property ($fell(CPU_STALL) |-> CPU_START)
    else $error("stall fell without start");
  AST_PERIPH: assert property (mode == dbs_pkg::MODE_HOST && CPU_STALL
      && state == dbs_pkg::ST_HOST_WAIT |-> PERIPH_RUN)
    else $error("device not released in host boot");
  AST_SETTLE: assert property ($rose(RSTN) |-> CPU_STALL [*4])
    else $error("cpu ran before straps were sampled");

  // copy handshakes: a request holds with its address and data until taken
  AST_BYTE_HOLD: assert property (s_byte_wait |=> ROM_RD_REQ && $stable(ROM_ADDR))
    else $error("byte read request dropped or moved before ack");
  AST_WORD_HOLD: assert property (s_word_wait
      |=> MEM_WR_REQ && $stable(MEM_WDATA) && $stable(MEM_WR_ADDR))
    else $error("word write request dropped or moved before ack");
  // reads and writes alternate, never both pending
  AST_ONE_REQ: assert property (!(ROM_RD_REQ && MEM_WR_REQ))
    else $error("byte read and word write requested together");
  AST_TIMING_COPY: assert property (ROM_RD_REQ || MEM_WR_REQ |-> ROM_DFLT_TIMING)
    else $error("copy ran without default rom timing");

  // start is a single pulse and the stall never comes back without reset
  AST_START_PULSE: assert property (CPU_START |=> !CPU_START)
    else $error("start pulse longer than one cycle");
  AST_STALL_STAYS: assert property (!CPU_STALL |=> !CPU_STALL)
    else $error("stall returned without reset");
  AST_START_ADDR: assert property (CPU_START |-> CPU_START_ADDR == `DBS_START_ADDR)
    else $error("cpu started away from address zero");
  AST_ONE_PORT: assert property (!(HPI_MEM_EN && PCI_MEM_EN))
    else $error("both host-side ports granted");

  // interrupt bit keeps until the cpu clears it
  AST_HINT_HOLD: assert property (hint && !CPU_INT_CLR |=> hint)
    else $error("interrupt bit lost without a clear");

  // register port: read data only in the cycle after a read
  AST_RDATA_IDLE: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data shown without a read");
  AST_RDATA_INFO: assert property (RD && ADDR == `DBS_OFS_INFO
      |=> RDATA == $past(info))
    else $error("info read returned wrong value");
  // status is sticky unless its clear bit is written
  AST_STICKY: assert property (status[`DBS_BIT_HINT_REFUSED]
      && !(wr_clear && WDATA[`DBS_BIT_HINT_REFUSED])
      |=> status[`DBS_BIT_HINT_REFUSED])
    else $error("sticky status bit lost");
  AST_CLEAR: assert property (wr_clear && WDATA[`DBS_BIT_HOST_DONE] && !evt[0]
      |=> !status[`DBS_BIT_HOST_DONE])
    else $error("status bit not cleared");
  // the interrupt line trails the enabled status by one cycle
  AST_IRQ_LEVEL: assert property (1'b1 |=> IRQ == $past(|(status & enable)))
    else $error("interrupt level does not follow enabled status");
endmodule

// >>> dbs_mem_model.sv
`timescale 1ns/1ns
module dbs_mem_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // ack pacing, 1 adds waits
  input wire logic SLOW,
  // rom byte reads
  input wire logic ROM_RD_REQ,
  input wire logic [9:0] ROM_ADDR,
  output logic ROM_RD_ACK,
  output logic [7:0] ROM_RD_DATA,
  // memory word writes
  input wire logic MEM_WR_REQ,
  input wire logic [7:0] MEM_WR_ADDR,
  input wire logic [31:0] MEM_WDATA,
  output logic MEM_WR_ACK
);
  logic [31:0] mem [256];
  logic [2:0] wait_cnt;
  int n_wr;
  wire [7:0] rom_byte = ROM_ADDR[7:0] ^ {ROM_ADDR[9:8], 6'h15};
  wire [2:0] lag = SLOW ? {1'b0, ROM_ADDR[1:0]} : 3'h0;
  // off-ack the data shows the inverse, so a stale byte cannot pass
  assign ROM_RD_DATA = ROM_RD_ACK ? rom_byte : ~rom_byte;
  // one-cycle acks after a wait that varies with the address when SLOW is set
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ROM_RD_ACK <= 1'b0;
      MEM_WR_ACK <= 1'b0;
      wait_cnt <= 3'h0;
      n_wr <= 0;
    end else begin
      ROM_RD_ACK <= 1'b0;
      MEM_WR_ACK <= 1'b0;
      wait_cnt <= 3'h0;
      if ((ROM_RD_REQ || MEM_WR_REQ) && !ROM_RD_ACK && !MEM_WR_ACK) begin
        wait_cnt <= wait_cnt + 3'h1;
        if (wait_cnt >= lag) begin
          ROM_RD_ACK <= ROM_RD_REQ;
          MEM_WR_ACK <= MEM_WR_REQ && !ROM_RD_REQ;
        end
      end
      // the word is taken at the ack edge only
      if (MEM_WR_ACK && MEM_WR_REQ) begin
        mem[MEM_WR_ADDR] <= MEM_WDATA;
        n_wr <= n_wr + 1;
      end
    end
  end
endmodule

// >>> dbs_pkg.sv
package dbs_pkg;
  typedef enum logic [1:0] {MODE_NONE, MODE_HOST, MODE_ROM} dbs_mode_t;
  typedef enum logic [2:0] {
    ST_SETTLE, ST_SAMPLE, ST_HOST_WAIT, ST_ROM_READ, ST_ROM_WRITE, ST_RUN
  } dbs_state_t;
endpackage

// >>> dbs_regs.svh
`ifndef DBS_REGS_SVH
`define DBS_REGS_SVH

// register offsets
`define DBS_OFS_STATUS 8'h00
`define DBS_OFS_CLEAR 8'h04
`define DBS_OFS_ENABLE 8'h08
`define DBS_OFS_INFO 8'h0c
// status bit positions
`define DBS_BIT_HOST_DONE 0
`define DBS_BIT_ROM_DONE 1
`define DBS_BIT_HINT_SET 2
`define DBS_BIT_HINT_REFUSED 3
`define DBS_NUM_EVT 4
// info register fields
`define DBS_INFO_MODE_LSB 0
`define DBS_INFO_PCI_BIT 2
`define DBS_INFO_STALL_BIT 3
`define DBS_INFO_HINT_BIT 4
// reset values
`define DBS_RST_ENABLE 4'h0
// boot mode pin codes
`define DBS_PIN_HOST 2'h1
`define DBS_PIN_ROM 2'h2
// counts
`define DBS_SYNC_CYC 2'h2
`define DBS_ROM_LAST_BYTE 10'h3ff
`define DBS_START_ADDR 32'h0000_0000
`endif

// >>> tb_dbs_boot_sequencer.sv
`timescale 1ns/1ns
module tb_dbs_boot_sequencer;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [1:0] BOOT_MODE = 2'h0;
  logic PCI_SEL = 1'b0;
  logic LITTLE_ENDIAN = 1'b1;
  logic HOST_INT_SET = 1'b0;
  logic CPU_INT_CLR = 1'b0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic SLOW = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  wire CPU_STALL, CPU_START, CPU_HOST_IRQ, PERIPH_RUN, HPI_MEM_EN, PCI_MEM_EN;
  wire ROM_RD_REQ, ROM_DFLT_TIMING, ROM_RD_ACK, MEM_WR_REQ, MEM_WR_ACK, IRQ;
  wire [31:0] CPU_START_ADDR, RDATA, MEM_WDATA;
  wire [7:0] ROM_RD_DATA, MEM_WR_ADDR;
  wire [9:0] ROM_ADDR;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] d;
  logic [31:0] ew;

  dbs_boot_sequencer dut_u (.CLK(CLK), .RSTN(RSTN), .BOOT_MODE(BOOT_MODE), .PCI_SEL(PCI_SEL),
    .LITTLE_ENDIAN(LITTLE_ENDIAN), .HOST_INT_SET(HOST_INT_SET), .CPU_INT_CLR(CPU_INT_CLR),
    .CPU_STALL(CPU_STALL), .CPU_START(CPU_START), .CPU_START_ADDR(CPU_START_ADDR),
    .CPU_HOST_IRQ(CPU_HOST_IRQ), .PERIPH_RUN(PERIPH_RUN), .HPI_MEM_EN(HPI_MEM_EN),
    .PCI_MEM_EN(PCI_MEM_EN), .ROM_RD_REQ(ROM_RD_REQ), .ROM_ADDR(ROM_ADDR),
    .ROM_DFLT_TIMING(ROM_DFLT_TIMING), .ROM_RD_ACK(ROM_RD_ACK), .ROM_RD_DATA(ROM_RD_DATA),
    .MEM_WR_REQ(MEM_WR_REQ), .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_WR_ACK(MEM_WR_ACK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .IRQ(IRQ));
  dbs_mem_model model_u (.CLK(CLK), .RSTN(RSTN), .SLOW(SLOW), .ROM_RD_REQ(ROM_RD_REQ),
    .ROM_ADDR(ROM_ADDR), .ROM_RD_ACK(ROM_RD_ACK), .ROM_RD_DATA(ROM_RD_DATA),
    .MEM_WR_REQ(MEM_WR_REQ), .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_WR_ACK(MEM_WR_ACK));

  // 100 MHz clock
  initial begin
    forever #5 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // register port: one-cycle strobes, read data in the next cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= v;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask

  task automatic pulse_set;
    @(posedge CLK);
    HOST_INT_SET <= 1'b1;
    @(posedge CLK);
    HOST_INT_SET <= 1'b0;
    #1;
  endtask

  // straps settle before release and stay put; clock runs throughout
  task automatic boot(input logic [1:0] m, input logic p, input logic le);
    @(posedge CLK);
    RSTN <= 1'b0;
    BOOT_MODE <= m;
    PCI_SEL <= p;
    LITTLE_ENDIAN <= le;
    repeat (5) @(posedge CLK);
    #1 chk("reset_outs", 32'({CPU_STALL, CPU_START, CPU_HOST_IRQ, PERIPH_RUN, HPI_MEM_EN,
      PCI_MEM_EN, ROM_RD_REQ, MEM_WR_REQ, ROM_DFLT_TIMING, IRQ}), 32'h200);
    @(posedge CLK);
    RSTN <= 1'b1;
    repeat (8) @(posedge CLK);
    #1;
  endtask

  function automatic logic [7:0] rb(input int a);
    logic [9:0] x;
    x = a[9:0];
    return x[7:0] ^ {x[9:8], 6'h15};
  endfunction

  initial begin
    // no boot, both codes that select it
    for (int m = 0; m < 4; m += 3) begin
      boot(m[1:0], 1'b0, 1'b1);
      chk("noboot_stall", CPU_STALL, 32'h0);
      chk("start_addr", CPU_START_ADDR, 32'h0);
      rd(8'h0c, d);
      chk("info_none", d, 32'h0);
      rd(8'h08, d);
      chk("enable_rst", d, 32'h0);
      rd(8'h10, d);
      chk("unmapped", d, 32'h0);
    end
    $display("test no_boot done");
    // host boot through each host-side port
    for (int p = 0; p < 2; p++) begin
      boot(2'h1, p[0], 1'b1);
      chk("host_stall", CPU_STALL, 32'h1);
      chk("periph_run", PERIPH_RUN, 32'h1);
      chk("grants", {HPI_MEM_EN, PCI_MEM_EN}, p[0] ? 32'h1 : 32'h2);
      rd(8'h0c, d);
      chk("info_host", d, p[0] ? 32'hd : 32'h9);
      pulse_set;
      chk("release", CPU_STALL, 32'h0);
      chk("start", CPU_START, 32'h1);
      chk("no_latch", CPU_HOST_IRQ, 32'h0);
    end
    // straps move after release: sampled values must hold
    @(posedge CLK);
    BOOT_MODE <= 2'h2;
    pulse_set;
    chk("refused_irq", CPU_HOST_IRQ, 32'h0);
    rd(8'h00, d);
    chk("status", d, 32'hd);
    rd(8'h0c, d);
    chk("info_held", d, 32'h15);
    wr(8'h08, 32'h8);
    repeat (2) @(posedge CLK);
    #1 chk("irq_on", IRQ, 32'h1);
    wr(8'h04, 32'h8);
    repeat (2) @(posedge CLK);
    #1 chk("irq_off", IRQ, 32'h0);
    @(posedge CLK);
    CPU_INT_CLR <= 1'b1;
    @(posedge CLK);
    CPU_INT_CLR <= 1'b0;
    pulse_set;
    chk("cpu_irq", CPU_HOST_IRQ, 32'h1);
    $display("test host_boot done");
    // rom boot, slow acks little-endian then prompt acks big-endian
    for (int le = 1; le >= 0; le--) begin
      SLOW <= le[0];
      boot(2'h2, 1'b0, le[0]);
      chk("rom_stall", CPU_STALL, 32'h1);
      chk("rom_timing", ROM_DFLT_TIMING, 32'h1);
      pulse_set;
      chk("set_no_release", CPU_STALL, 32'h1);
      for (int w = 0; CPU_START !== 1'b1; w++) begin
        if (w == 20000) begin
          err_total++;
          give_verdict();
        end
        @(posedge CLK);
        #1;
      end
      chk("words_done", 32'(model_u.n_wr), 32'd256);
      chk("rom_release", CPU_STALL, 32'h0);
      chk("rom_timing_off", ROM_DFLT_TIMING, 32'h0);
      for (int i = 0; i < 256; i++) begin
        ew = le ? {rb(4*i+3), rb(4*i+2), rb(4*i+1), rb(4*i)}
                : {rb(4*i), rb(4*i+1), rb(4*i+2), rb(4*i+3)};
        chk("rom_word", model_u.mem[i], ew);
      end
      rd(8'h00, d);
      chk("rom_done", 32'(d[1]), 32'h1);
      $display("test rom_boot done");
    end
    give_verdict();
  end
endmodule
